// ===== verilog/pcd_top.v
// PHY coding path, clock select, crossover, parallel detect and cable test.
// Assumes APB master on CLOCK; line pins are bit-rate samples on CLOCK.
//
// Summary of operation
// R1: MII transmit nibbles are serialised one line bit per clock.
// R2: Transmit path codes 4B/5B, then scrambles, then converts NRZ to NRZI.
// R3: Scrambler is an 11-bit LFSR repeating every 2047 bits.
// R4: Receiver descrambles with the same LFSR sequence as the transmitter.
// R5: Receive converts NRZI to NRZ, descrambles, decodes 4B/5B, outputs nibbles.
// R6: Bus control register chooses 125, 62.5, 41.66 or 25 MHz system clock.
// R7: 10M receive splits Manchester into clock and data; clock runs in idle.
// R8: Two crossover algorithms; the vendor one is selected after reset.
// R9: Port control bit 10 disables auto crossover; host picks the pair.
// R10: Without partner negotiation, speed follows detected receive signal type.
// R11: Writing bit 12 starts cable test; hardware clears it when finished.
// R12: Result bits 14:13 give normal, open, short or failed test.
// R13: If the partner cannot be silenced, skip measurement and report 11.
// R14: Distance is a 9-bit count in bits 8:0, about 0.4 m each.
// R15: Host disables auto crossover before starting a cable test.
// R16: Special control and cable test register sits at offset 0xF4.
// R17: Host trusts result and distance only after bit 12 reads zero.
`timescale 1ns/1ps
`include "pcd_defines.vh"
module pcd_top (
  // Clock and reset
  input wire CLOCK,
  input wire RST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg IRQ,
  // MII transmit side
  input wire TX_EN,
  input wire [3:0] TXD,
  output reg TX_NIB_TAKEN,
  output reg TX_NRZI,
  // 100M receive line and MII receive side
  input wire RX_NRZI,
  input wire RX_SIG_DET,
  output reg [3:0] RXD,
  output reg RX_NIB_VALID,
  output reg RX_DV,
  // 10M receive
  input wire RX_MAN,
  input wire RX10_SQUELCH_OK,
  output reg RX10_CLK,
  output reg RX10_DATA,
  output reg RX10_DV,
  // Clock synthesiser select
  output reg [1:0] SYS_CLK_SEL,
  // Crossover and negotiation
  input wire LINK_UP,
  input wire AN_EN,
  input wire LP_AN_SEEN,
  input wire FAST_SIG_SEEN,
  output reg MDIX,
  output reg STD_XOVER,
  output reg AN_ADV_TX,
  output reg SPEED_100,
  // Cable test front end
  input wire PARTNER_QUIET,
  input wire ECHO_OPEN,
  input wire ECHO_SHORT,
  output reg TDR_PULSE
);
  localparam ST_IDLE = 3'h0;
  localparam ST_J = 3'h1;
  localparam ST_K = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_T = 3'h4;
  localparam ST_R = 3'h5;
  localparam DG_IDLE = 2'h0;
  localparam DG_QUIET = 2'h1;
  localparam DG_MEAS = 2'h2;

  function [4:0] enc4b5b;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc4b5b = 5'h1e;
        4'h1: enc4b5b = 5'h09;
        4'h2: enc4b5b = 5'h14;
        4'h3: enc4b5b = 5'h15;
        4'h4: enc4b5b = 5'h0a;
        4'h5: enc4b5b = 5'h0b;
        4'h6: enc4b5b = 5'h0e;
        4'h7: enc4b5b = 5'h0f;
        4'h8: enc4b5b = 5'h12;
        4'h9: enc4b5b = 5'h13;
        4'ha: enc4b5b = 5'h16;
        4'hb: enc4b5b = 5'h17;
        4'hc: enc4b5b = 5'h1a;
        4'hd: enc4b5b = 5'h1b;
        4'he: enc4b5b = 5'h1c;
        default: enc4b5b = 5'h1d;
      endcase
    end
  endfunction

  // Bit 4 flags an invalid code group
  function [4:0] dec5b4b;
    input [4:0] s;
    integer i;
    begin
      dec5b4b = 5'h10;
      for (i = 0; i < 16; i = i + 1) begin
        if (enc4b5b(i[3:0]) == s)
          dec5b4b = {1'b0, i[3:0]};
      end
    end
  endfunction

  // x^11 + x^9 + 1 advance, shared by both directions
  function [10:0] lfsr_step;
    input [10:0] l;
    begin
      lfsr_step = {l[9:0], l[10] ^ l[8]};
    end
  endfunction

  // Register bus
  reg [1:0] busctl_reg;
  reg [2:0] portctl_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg diag_en_reg;
  reg [1:0] diag_res_reg;
  reg [8:0] diag_dist_reg;
  wire wr = PSEL & PENABLE & PREADY & PWRITE;
  wire rd_setup = PSEL & ~PENABLE;
  reg [31:0] rdata_next;
  reg hit_next;

  always @* begin
    rdata_next = 32'h0;
    hit_next = 1'b1;
    case (PADDR)
      `PCD_ADDR_BUSCTL: rdata_next[1:0] = busctl_reg;
      `PCD_ADDR_IRQ_STAT: rdata_next[2:0] = irq_stat_reg;
      `PCD_ADDR_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
      `PCD_ADDR_PORTCTL: rdata_next[10:8] = portctl_reg;
      `PCD_ADDR_DIAG:
        rdata_next[15:0] = {1'b0, diag_res_reg, diag_en_reg, 3'h0,
          diag_dist_reg}; // R16
      default: hit_next = 1'b0;
    endcase
  end

  // One wait-free access phase: ready rises the cycle after setup
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= rd_setup;
      if (rd_setup) begin
        PRDATA <= rdata_next;
        PSLVERR <= ~hit_next;
      end
    end
  end

  // Transmit path
  reg [2:0] tx_st_reg;
  reg [4:0] tx_sym_reg;
  reg [2:0] tx_bit_reg;
  reg [10:0] tx_lfsr_reg;
  wire tx_sym_end = (tx_bit_reg == 3'h4);
  reg [2:0] tx_st_next;
  reg [4:0] tx_sym_next;

  always @* begin
    tx_st_next = tx_st_reg;
    tx_sym_next = `PCD_SYM_IDLE;
    case (tx_st_reg)
      ST_IDLE: if (TX_EN) begin
        tx_st_next = ST_J;
        tx_sym_next = `PCD_SYM_J;
      end
      ST_J: begin
        tx_st_next = ST_K;
        tx_sym_next = `PCD_SYM_K;
      end
      ST_K, ST_DATA: if (TX_EN) begin
        tx_st_next = ST_DATA;
        tx_sym_next = enc4b5b(TXD); // R2
      end else begin
        tx_st_next = ST_T;
        tx_sym_next = `PCD_SYM_T;
      end
      ST_T: begin
        tx_st_next = ST_R;
        tx_sym_next = `PCD_SYM_R;
      end
      ST_R: tx_st_next = ST_IDLE;
      default: tx_st_next = ST_IDLE;
    endcase
  end

  // Line bit rate stands for 125 MHz; one code bit per clock
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tx_st_reg <= ST_IDLE;
      tx_sym_reg <= `PCD_SYM_IDLE;
      tx_bit_reg <= 3'h0;
      tx_lfsr_reg <= `PCD_LFSR_SEED;
      TX_NRZI <= 1'b0;
      TX_NIB_TAKEN <= 1'b0;
    end else begin
      tx_lfsr_reg <= lfsr_step(tx_lfsr_reg); // R3
      tx_bit_reg <= tx_sym_end ? 3'h0 : tx_bit_reg + 3'h1; // R1
      TX_NIB_TAKEN <= tx_sym_end & TX_EN &
        (tx_st_reg == ST_K || tx_st_reg == ST_DATA);
      if (tx_sym_end) begin
        tx_st_reg <= tx_st_next;
        tx_sym_reg <= tx_sym_next;
      end else begin
        tx_sym_reg <= {tx_sym_reg[3:0], 1'b0}; // R1
      end
      if (tx_sym_reg[4] ^ tx_lfsr_reg[10]) // R2
        TX_NRZI <= ~TX_NRZI;
    end
  end

  // 100M receive path
  reg rx_prev_reg;
  reg [10:0] rx_lfsr_reg;
  reg [3:0] rx_lock_cnt_reg;
  reg [9:0] rx_sh_reg;
  reg [2:0] rx_bit_reg;
  reg rx_aligned_reg;
  wire rx_nrz = RX_NRZI ^ rx_prev_reg; // R5
  wire rx_locked = (rx_lock_cnt_reg == 4'hb);
  // Key for this bit is the next sequence bit, not the oldest one held
  wire [10:0] rx_lfsr_adv = lfsr_step(rx_lfsr_reg);
  wire rx_plain = rx_nrz ^ rx_lfsr_adv[0]; // R4
  wire [9:0] rx_sh_next = {rx_sh_reg[8:0], rx_plain};
  wire [4:0] rx_dec = dec5b4b(rx_sh_next[4:0]);
  wire rx_sym_end = (rx_bit_reg == 3'h4);
  wire rx_err_ev = rx_aligned_reg & rx_sym_end & rx_dec[4] &
    (rx_sh_next[4:0] != `PCD_SYM_T);

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_prev_reg <= 1'b0;
      rx_lfsr_reg <= 11'h0;
      rx_lock_cnt_reg <= 4'h0;
      rx_sh_reg <= 10'h0;
      rx_bit_reg <= 3'h0;
      rx_aligned_reg <= 1'b0;
      RXD <= 4'h0;
      RX_NIB_VALID <= 1'b0;
      RX_DV <= 1'b0;
    end else begin
      rx_prev_reg <= RX_NRZI;
      RX_NIB_VALID <= 1'b0;
      // Idle is all ones, so the key seeds from the inverted stream
      if (!RX_SIG_DET) begin
        rx_lock_cnt_reg <= 4'h0;
        rx_aligned_reg <= 1'b0;
        RX_DV <= 1'b0;
      end else if (!rx_locked) begin
        rx_lfsr_reg <= {rx_lfsr_reg[9:0], ~rx_nrz}; // R4
        rx_lock_cnt_reg <= rx_lock_cnt_reg + 4'h1;
      end else begin
        rx_lfsr_reg <= rx_lfsr_adv; // R4
        rx_sh_reg <= rx_sh_next;
        rx_bit_reg <= rx_sym_end ? 3'h0 : rx_bit_reg + 3'h1;
        if (!rx_aligned_reg && rx_sh_next == `PCD_JK) begin
          rx_aligned_reg <= 1'b1;
          rx_bit_reg <= 3'h0;
          RX_DV <= 1'b1;
        end else if (rx_aligned_reg && rx_sym_end) begin
          if (rx_dec[4]) begin
            rx_aligned_reg <= 1'b0;
            RX_DV <= 1'b0;
          end else begin
            RXD <= rx_dec[3:0]; // R5
            RX_NIB_VALID <= 1'b1;
          end
        end
      end
    end
  end

  // 10M Manchester receive, two samples per bit
  reg man_prev_reg;
  reg man_phase_reg;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      man_prev_reg <= 1'b0;
      man_phase_reg <= 1'b0;
      RX10_CLK <= 1'b0;
      RX10_DATA <= 1'b0;
      RX10_DV <= 1'b0;
    end else begin
      man_prev_reg <= RX_MAN;
      // Free-running so the clock stays alive between frames
      RX10_CLK <= man_phase_reg; // R7
      RX10_DV <= RX10_SQUELCH_OK; // R7
      if (RX10_SQUELCH_OK && RX_MAN != man_prev_reg) begin
        man_phase_reg <= 1'b0;
        RX10_DATA <= RX_MAN; // R7
      end else begin
        man_phase_reg <= ~man_phase_reg;
      end
    end
  end

  // Crossover, parallel detect, clock select
  reg [5:0] xo_cnt_reg;
  wire manual = portctl_reg[2];

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      xo_cnt_reg <= 6'h0;
      MDIX <= 1'b0;
      STD_XOVER <= 1'b0; // R8
      AN_ADV_TX <= 1'b0;
      SPEED_100 <= 1'b0;
      SYS_CLK_SEL <= `PCD_CLK_125;
    end else begin
      SYS_CLK_SEL <= busctl_reg; // R6
      STD_XOVER <= portctl_reg[0]; // R8
      AN_ADV_TX <= AN_EN; // R10
      if (AN_EN && !LP_AN_SEEN && RX_SIG_DET | RX10_SQUELCH_OK)
        SPEED_100 <= FAST_SIG_SEEN; // R10
      if (manual) begin
        MDIX <= portctl_reg[1]; // R9
      end else if (!LINK_UP) begin
        xo_cnt_reg <= xo_cnt_reg + 6'h1;
        // Vendor flavour toggles pseudo-randomly to break lockstep
        if (xo_cnt_reg == `PCD_XOVER_CYC - 1)
          MDIX <= portctl_reg[0] ? ~MDIX : tx_lfsr_reg[0];
      end
    end
  end

  // Cable test
  reg [1:0] dg_st_reg;
  reg [7:0] dg_cnt_reg;
  reg dg_done_ev;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dg_st_reg <= DG_IDLE;
      dg_cnt_reg <= 8'h0;
      dg_done_ev <= 1'b0;
      diag_en_reg <= 1'b0;
      diag_res_reg <= `PCD_RES_NORMAL;
      diag_dist_reg <= 9'h0;
      TDR_PULSE <= 1'b0;
    end else begin
      dg_done_ev <= 1'b0;
      TDR_PULSE <= 1'b0;
      case (dg_st_reg)
        DG_IDLE: if (wr && PADDR == `PCD_ADDR_DIAG &&
            PWDATA[`PCD_DIAG_EN]) begin
          diag_en_reg <= 1'b1; // R11
          dg_cnt_reg <= 8'h0;
          dg_st_reg <= DG_QUIET;
        end
        DG_QUIET: if (PARTNER_QUIET) begin
          TDR_PULSE <= 1'b1;
          diag_dist_reg <= 9'h0;
          dg_st_reg <= DG_MEAS;
        end else if (dg_cnt_reg == `PCD_QUIET_CYC - 1) begin
          diag_res_reg <= `PCD_RES_FAIL; // R13
          diag_en_reg <= 1'b0;
          dg_done_ev <= 1'b1;
          dg_st_reg <= DG_IDLE;
        end else begin
          dg_cnt_reg <= dg_cnt_reg + 8'h1;
        end
        DG_MEAS: begin
          // One count per clock; the 0.4 m scale is the analogue's job
          if (ECHO_OPEN | ECHO_SHORT |
              (diag_dist_reg == `PCD_DIST_MAX)) begin
            diag_res_reg <= ECHO_SHORT ? `PCD_RES_SHORT :
              ECHO_OPEN ? `PCD_RES_OPEN : `PCD_RES_NORMAL; // R12
            diag_en_reg <= 1'b0; // R11
            dg_done_ev <= 1'b1;
            dg_st_reg <= DG_IDLE;
          end else begin
            diag_dist_reg <= diag_dist_reg + 9'h1; // R14
          end
        end
        default: dg_st_reg <= DG_IDLE;
      endcase
    end
  end

  // Software registers and interrupts; a new event beats a clear
  reg speed_q;
  wire [2:0] ev = {SPEED_100 ^ speed_q, rx_err_ev, dg_done_ev};
  wire [2:0] stat_next = (irq_stat_reg &
    ~((wr && PADDR == `PCD_ADDR_IRQ_STAT) ? PWDATA[2:0] : 3'h0)) | ev;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      busctl_reg <= `PCD_BUSCTL_RST;
      portctl_reg <= `PCD_PORTCTL_RST;
      irq_mask_reg <= 3'h0;
      irq_stat_reg <= 3'h0;
      speed_q <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      speed_q <= SPEED_100;
      irq_stat_reg <= stat_next;
      IRQ <= |(stat_next & irq_mask_reg);
      if (wr) begin
        case (PADDR)
          `PCD_ADDR_BUSCTL: busctl_reg <= PWDATA[1:0]; // R6
          `PCD_ADDR_IRQ_MASK: irq_mask_reg <= PWDATA[2:0];
          `PCD_ADDR_PORTCTL: portctl_reg <= PWDATA[10:8]; // R9
          default: busctl_reg <= busctl_reg;
        endcase
      end
    end
  end
endmodule

// ===== verilog/pcd_defines.vh
// Constants for the PHY coding and cable diagnostic block.
// Assumes inclusion by pcd_top.v and by the dv checker and bench; definitions only.
`ifndef PCD_DEFINES_VH
`define PCD_DEFINES_VH
// Register byte addresses
`define PCD_ADDR_BUSCTL 8'h20
`define PCD_ADDR_IRQ_STAT 8'he0
`define PCD_ADDR_IRQ_MASK 8'he4
`define PCD_ADDR_PORTCTL 8'hec
`define PCD_ADDR_DIAG 8'hf4
// Diagnostic register fields
`define PCD_DIAG_EN 12
`define PCD_DIAG_RES_HI 14
`define PCD_DIAG_RES_LO 13
`define PCD_DIAG_DIST_HI 8
// Port control fields
`define PCD_PC_MANUAL 10
`define PCD_PC_MDIX 9
`define PCD_PC_STD_ALG 8
// Result codes
`define PCD_RES_NORMAL 2'h0
`define PCD_RES_OPEN 2'h1
`define PCD_RES_SHORT 2'h2
`define PCD_RES_FAIL 2'h3
// Interrupt status bits
`define PCD_IRQ_DIAG 0
`define PCD_IRQ_RXERR 1
`define PCD_IRQ_SPEED 2
// Reset values
`define PCD_BUSCTL_RST 2'h0
`define PCD_PORTCTL_RST 3'h0
// Clock select codes: 125, 62.5, 41.66, 25 MHz
`define PCD_CLK_125 2'h0
`define PCD_CLK_25 2'h3
// Line symbols
`define PCD_SYM_IDLE 5'h1f
`define PCD_SYM_J 5'h18
`define PCD_SYM_K 5'h11
`define PCD_SYM_T 5'h0d
`define PCD_SYM_R 5'h07
`define PCD_JK 10'h311
// Scrambler
`define PCD_LFSR_W 11
`define PCD_LFSR_SEED 11'h7ff
// Timing (ns) and derived cycles at 10 ns
`define PCD_CLK_NS 10
`define PCD_QUIET_NS 2000
`define PCD_QUIET_CYC (`PCD_QUIET_NS / `PCD_CLK_NS)
`define PCD_XOVER_NS 640
`define PCD_XOVER_CYC (`PCD_XOVER_NS / `PCD_CLK_NS)
`define PCD_DIST_MAX 9'h1ff
`endif

// ===== dv/pcd_top_properties.sv
// Concurrent checks on the pins of the coding and cable test block.
// Assumes a bind to pcd_top; one clock, asynchronous low reset.
`timescale 1ns/1ps
`include "pcd_defines.vh"
module pcd_props (
  // Clock and reset
  input wire CLOCK,
  input wire RST_N,
  // APB
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire PREADY,
  input wire PSLVERR,
  // Line and front end
  input wire TX_NIB_TAKEN,
  input wire RX10_SQUELCH_OK,
  input wire RX10_DV,
  input wire [1:0] SYS_CLK_SEL,
  input wire STD_XOVER,
  input wire PARTNER_QUIET,
  input wire TDR_PULSE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire wr = PSEL && PENABLE && PREADY && PWRITE;
  wire wr_bus = wr && (PADDR == `PCD_ADDR_BUSCTL);
  wire wr_port = wr && (PADDR == `PCD_ADDR_PORTCTL);
  wire mapped = (PADDR == `PCD_ADDR_BUSCTL) || (PADDR == `PCD_ADDR_IRQ_STAT)
    || (PADDR == `PCD_ADDR_IRQ_MASK) || (PADDR == `PCD_ADDR_PORTCTL)
    || (PADDR == `PCD_ADDR_DIAG);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE && PREADY;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (access_s |=> !PREADY)
    else $error("ready held too long");
  unmapped_error_a: assert property (access_s |-> PSLVERR == !mapped)
    else $error("error flag wrong for address");
  pulse_needs_quiet_a: assert property (TDR_PULSE |-> $past(PARTNER_QUIET))
    else $error("test pulse while partner active");
  pulse_single_a: assert property (TDR_PULSE |=> !TDR_PULSE [*2])
    else $error("test pulse repeated");
  nibble_spacing_a: assert property (TX_NIB_TAKEN |=> !TX_NIB_TAKEN [*4])
    else $error("nibbles closer than five bits");
  squelch_valid_a: assert property ($rose(RX10_SQUELCH_OK) |=> RX10_DV)
    else $error("no frame after squelch open");
  clk_sel_write_a: assert property (!$stable(SYS_CLK_SEL) |->
    $past(wr_bus) || $past(wr_bus, 2))
    else $error("clock select moved without write");
  xover_alg_write_a: assert property (!$stable(STD_XOVER) |->
    $past(wr_port) || $past(wr_port, 2))
    else $error("crossover algorithm moved without write");
endmodule
bind pcd_top pcd_props pcd_props_i (.CLOCK(CLOCK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_NIB_TAKEN(TX_NIB_TAKEN),
  .RX10_SQUELCH_OK(RX10_SQUELCH_OK), .RX10_DV(RX10_DV),
  .SYS_CLK_SEL(SYS_CLK_SEL), .STD_XOVER(STD_XOVER),
  .PARTNER_QUIET(PARTNER_QUIET), .TDR_PULSE(TDR_PULSE));

// ===== dv/pcd_cable_model.sv
// Far end model: link partner silence and cable echo.
// Assumes TDR_PULSE from the block; echo holds until partner speaks.
`timescale 1ns/1ps
module pcd_cable_model (
  // Clock and reset
  input wire CLOCK,
  input wire RST_N,
  // Scenario control
  input wire quiet_req,
  input wire [1:0] fault,
  input wire [8:0] echo_dist,
  // Front end pins
  input wire TDR_PULSE,
  output reg PARTNER_QUIET,
  output reg ECHO_OPEN,
  output reg ECHO_SHORT
);
  reg [3:0] hush_reg;
  reg [9:0] cnt_reg;
  always @* PARTNER_QUIET = hush_reg[3];
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hush_reg <= 4'h0;
      cnt_reg <= 10'h3ff;
      ECHO_OPEN <= 1'b0;
      ECHO_SHORT <= 1'b0;
    end else begin
      // Slow to fall silent, as a real partner is
      hush_reg <= {hush_reg[2:0], quiet_req};
      if (TDR_PULSE)
        cnt_reg <= 10'h0;
      else if (cnt_reg != 10'h3ff)
        cnt_reg <= cnt_reg + 10'h1;
      if (!hush_reg[3]) begin
        ECHO_OPEN <= 1'b0;
        ECHO_SHORT <= 1'b0;
      end else if (cnt_reg == {1'b0, echo_dist}) begin
        ECHO_OPEN <= (fault == 2'h1);
        ECHO_SHORT <= (fault == 2'h2);
      end
    end
  end
endmodule

// ===== dv/pcd_top_tb.sv
// Self-checking bench for the coding path and cable test block.
// Assumes pcd_top, the cable model and the bound checker are compiled.
`timescale 1ns/1ps
`include "pcd_defines.vh"
module pcd_top_tb;
  reg CLOCK, RST_N, PSEL, PENABLE, PWRITE, TX_EN, RX_NRZI, RX_SIG_DET;
  reg RX_MAN, RX10_SQUELCH_OK, LINK_UP, AN_EN, LP_AN_SEEN, FAST_SIG_SEEN;
  reg [7:0] PADDR;
  reg [31:0] PWDATA, rd;
  reg [3:0] TXD;
  reg [3:0] rx_q [0:15];
  reg [1:0] fault;
  reg [8:0] echo_dist;
  reg quiet_req, loop_on, perr;
  reg [1:0] man_cnt;
  wire [31:0] PRDATA;
  wire [3:0] RXD;
  wire [1:0] SYS_CLK_SEL;
  wire PREADY, PSLVERR, IRQ, TX_NIB_TAKEN, TX_NRZI, RX_NIB_VALID, RX_DV;
  wire RX10_CLK, RX10_DATA, RX10_DV, MDIX, STD_XOVER, AN_ADV_TX, SPEED_100;
  wire PARTNER_QUIET, ECHO_OPEN, ECHO_SHORT, TDR_PULSE;
  integer err_total, tests_run, rxn, i;
  pcd_top pcd_top_i (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .TX_EN(TX_EN), .TXD(TXD), .TX_NIB_TAKEN(TX_NIB_TAKEN),
    .TX_NRZI(TX_NRZI), .RX_NRZI(RX_NRZI), .RX_SIG_DET(RX_SIG_DET),
    .RXD(RXD), .RX_NIB_VALID(RX_NIB_VALID), .RX_DV(RX_DV),
    .RX_MAN(RX_MAN), .RX10_SQUELCH_OK(RX10_SQUELCH_OK),
    .RX10_CLK(RX10_CLK), .RX10_DATA(RX10_DATA), .RX10_DV(RX10_DV),
    .SYS_CLK_SEL(SYS_CLK_SEL), .LINK_UP(LINK_UP), .AN_EN(AN_EN),
    .LP_AN_SEEN(LP_AN_SEEN), .FAST_SIG_SEEN(FAST_SIG_SEEN), .MDIX(MDIX),
    .STD_XOVER(STD_XOVER), .AN_ADV_TX(AN_ADV_TX), .SPEED_100(SPEED_100),
    .PARTNER_QUIET(PARTNER_QUIET), .ECHO_OPEN(ECHO_OPEN),
    .ECHO_SHORT(ECHO_SHORT), .TDR_PULSE(TDR_PULSE));
  pcd_cable_model pcd_cable_model_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .quiet_req(quiet_req), .fault(fault), .echo_dist(echo_dist),
    .TDR_PULSE(TDR_PULSE), .PARTNER_QUIET(PARTNER_QUIET),
    .ECHO_OPEN(ECHO_OPEN), .ECHO_SHORT(ECHO_SHORT));
  always #5 CLOCK = ~CLOCK;
  // Line loopback and a steady Manchester stream
  always @(posedge CLOCK) begin
    RX_NRZI <= loop_on ? TX_NRZI : 1'b0;
    // Alternating ones and zeros: one mid-bit edge every two samples
    RX_MAN <= man_cnt[1] ^ man_cnt[0];
    man_cnt <= man_cnt + 2'h1;
    if (RX_DV === 1'b1 && RX_NIB_VALID === 1'b1 && rxn < 16) begin
      rx_q[rxn] <= RXD;
      rxn <= rxn + 1;
    end
  end
  task chk(input [31:0] got, input [31:0] lo, input [31:0] hi,
    input [8*16-1:0] what);
    begin
      tests_run = tests_run + 1;
      if (got < lo || got > hi || ^got === 1'bx) begin
        err_total = err_total + 1;
        $display("mismatch %0t %0s got %h", $time, what, got);
      end
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge CLOCK);
      #1;
    end
  endtask
  // Read data and error are taken only at the ready edge
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge CLOCK);
      end
      chk(PREADY, 1, 1, "apb ready");
      rd = PRDATA;
      perr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask
  task t_regs;
    begin
      apb(0, `PCD_ADDR_BUSCTL, 0);
      chk(rd, 0, 0, "busctl reset");
      apb(0, `PCD_ADDR_PORTCTL, 0);
      chk(STD_XOVER, 0, 0, "vendor default");
      apb(0, 8'h44, 0);
      chk(perr, 1, 1, "unmapped");
      apb(0, `PCD_ADDR_DIAG, 0);
      chk(perr, 0, 0, "diag mapped");
    end
  endtask
  task t_clksel;
    begin
      for (i = 3; i >= 0; i = i - 1) begin
        apb(1, `PCD_ADDR_BUSCTL, i);
        wt(2);
        chk(SYS_CLK_SEL, i, i, "clock select");
      end
    end
  endtask
  task t_xover;
    begin
      apb(1, `PCD_ADDR_PORTCTL, 32'h600);
      wt(2);
      chk(MDIX, 1, 1, "manual mdix");
      apb(1, `PCD_ADDR_PORTCTL, 32'h500);
      wt(2);
      chk(MDIX, 0, 0, "manual mdi");
      chk(STD_XOVER, 1, 1, "standard alg");
      apb(1, `PCD_ADDR_PORTCTL, 32'h100);
      wt(2);
      rd[0] = MDIX;
      wt(64);
      chk(MDIX, !rd[0], !rd[0], "auto toggle");
    end
  endtask
  task t_diag(input q, input [1:0] f, input [8:0] d, input [1:0] res);
    integer n;
    begin
      n = 0;
      apb(1, `PCD_ADDR_PORTCTL, 32'h400);
      @(posedge CLOCK);
      quiet_req <= q;
      fault <= f;
      echo_dist <= d;
      apb(1, `PCD_ADDR_DIAG, 32'h1000);
      rd = 32'h1000;
      while (rd[12] !== 1'b0 && n < 400) begin
        apb(0, `PCD_ADDR_DIAG, 0);
        n = n + 1;
      end
      chk(rd[12], 0, 0, "test done");
      chk(rd[14:13], res, res, "result");
      if (f != 2'h0)
        chk(rd[8:0], d, d + 4, "distance");
      wt(2);
      chk(IRQ, 0, 0, "irq masked");
      apb(1, `PCD_ADDR_IRQ_MASK, 1);
      wt(2);
      chk(IRQ, 1, 1, "irq raised");
      apb(1, `PCD_ADDR_IRQ_STAT, 1);
      wt(2);
      chk(IRQ, 0, 0, "irq cleared");
      apb(1, `PCD_ADDR_IRQ_MASK, 0);
      quiet_req <= 1'b0;
      wt(8);
    end
  endtask
  // Transmit looped to receive; nibbles must return in order
  task t_loop;
    integer n;
    begin
      @(posedge CLOCK);
      loop_on <= 1'b1;
      // Line must carry real idle before the key is seeded
      repeat (4) @(posedge CLOCK);
      RX_SIG_DET <= 1'b1;
      repeat (60) @(posedge CLOCK);
      TX_EN <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
        n = 0;
        @(posedge CLOCK);
        while (TX_NIB_TAKEN !== 1'b1 && n < 50) begin
          n = n + 1;
          @(posedge CLOCK);
        end
        TXD <= i[3:0] + 4'h1;
      end
      TX_EN <= 1'b0;
      wt(60);
      chk(rxn, 16, 16, "rx count");
      for (i = 0; i < 16; i = i + 1)
        chk(rx_q[i], i, i, "rx nibble");
    end
  endtask
  task t_detect;
    begin
      @(posedge CLOCK);
      FAST_SIG_SEEN <= 1'b1;
      wt(50);
      chk(SPEED_100, 1, 1, "detect 100");
      chk(AN_ADV_TX, 1, 1, "still adv");
      @(posedge CLOCK);
      FAST_SIG_SEEN <= 1'b0;
      wt(50);
      chk(SPEED_100, 0, 0, "detect 10");
    end
  endtask
  task t_10m;
    integer tg;
    begin
      tg = 0;
      wt(16);
      rd[0] = RX10_CLK;
      for (i = 0; i < 16; i = i + 1) begin
        wt(1);
        if (RX10_CLK !== rd[0])
          tg = tg + 1;
        rd[0] = RX10_CLK;
      end
      chk(tg, 2, 16, "idle rx clock");
      @(posedge CLOCK);
      RX10_SQUELCH_OK <= 1'b1;
      wt(3);
      chk(RX10_DV, 1, 1, "frame valid");
      tg = 0;
      rd[0] = RX10_DATA;
      for (i = 0; i < 16; i = i + 1) begin
        wt(1);
        if (RX10_DATA !== rd[0])
          tg = tg + 1;
        rd[0] = RX10_DATA;
      end
      chk(tg, 6, 8, "rx data toggles");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    {CLOCK, RST_N, PSEL, PENABLE, PWRITE, TX_EN, RX_NRZI, RX_SIG_DET} = 0;
    {RX_MAN, RX10_SQUELCH_OK, LINK_UP, LP_AN_SEEN, FAST_SIG_SEEN} = 0;
    man_cnt = 2'h0;
    {PADDR, PWDATA, TXD, fault, echo_dist, quiet_req, loop_on} = 0;
    AN_EN = 1'b1;
    err_total = 0;
    tests_run = 0;
    rxn = 0;
    repeat (8) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_regs;
    t_clksel;
    t_xover;
    t_diag(1'b1, 2'h1, 9'd40, `PCD_RES_OPEN);
    t_diag(1'b1, 2'h2, 9'd100, `PCD_RES_SHORT);
    t_diag(1'b1, 2'h0, 9'd0, `PCD_RES_NORMAL);
    t_diag(1'b0, 2'h0, 9'd0, `PCD_RES_FAIL);
    t_loop;
    t_detect;
    t_10m;
    report_and_stop;
  end
  // Hang guard, well past the longest expected run
  initial begin
    #400000;
    err_total = err_total + 1;
    report_and_stop;
  end
endmodule
